//--- design/dsd_segment_decoder.v
// input latch and segment decoder for a 12-bit current steering converter
//
// What this block does
// - sample word is 12 parallel bits, highest line msb, line zero lsb
// - whole word captured on each rising clock edge only, while power-down is low
// - capture and decode keep up with clocks up to 125 MSPS
// - power-down input high enters low-power state, low means normal operation
// - power-down input has no pull-down in this block, the testbench drives it low for normal operation
// - top 5 bits decode to thermometer of 31 major segments
// - next 4 bits decode to thermometer of 15 middle segments
// - low bits pass straight through as binary-weighted selects
// - each source steered to exactly one of the two outputs
// - true select and complement produced with matched timing
// - all ones steers all primary, all zeros all complementary
// - word is unsigned 0 to 4095, primary current rises with code
`timescale 1ns/100ps
`default_nettype none
`include "dsd_defines.vh"

module dsd_segment_decoder #(
   parameter WORD_W = `DSD_WORD_W,
   parameter MAJOR_BITS = `DSD_MAJOR_BITS,
   parameter MIDDLE_BITS = `DSD_MIDDLE_BITS,
   parameter LOW_BITS = `DSD_LOW_BITS
) (
   input wire ref_clk,
   input wire rst_n,
   input wire sample_msb,
   input wire [WORD_W-3:0] sample_middle_bits,
   input wire sample_lsb,
   input wire power_down,
   output reg [(1<<MAJOR_BITS)-2:0] major_sel,
   output reg [(1<<MAJOR_BITS)-2:0] major_sel_n,
   output reg [(1<<MIDDLE_BITS)-2:0] middle_sel,
   output reg [(1<<MIDDLE_BITS)-2:0] middle_sel_n,
   output reg [LOW_BITS-1:0] low_sel,
   output reg [LOW_BITS-1:0] low_sel_n,
   output reg low_power,
   output reg [WORD_W-1:0] latched_word
);

   localparam MAJOR_SEGS = (1<<MAJOR_BITS)-1;
   localparam MIDDLE_SEGS = (1<<MIDDLE_BITS)-1;
   localparam MAJOR_LSB = WORD_W-MAJOR_BITS;
   localparam MIDDLE_LSB = LOW_BITS;

   // ************************************************************
   // thermometer decode
   // ************************************************************

   // sets the lowest 'value' bits of a 31-wide vector
   function [30:0] dsd_therm;
      input [4:0] value;
      integer i;
      begin
         dsd_therm = 31'h0000_0000;
         for (i = 0; i < 31; i = i + 1) begin
            if (i < value)
               dsd_therm[i] = 1'b1;
         end
      end
   endfunction

   wire [WORD_W-1:0] sample_word;
   reg [WORD_W-1:0] next_word;
   wire [30:0] major_therm;
   wire [30:0] middle_therm;
   wire [MAJOR_BITS-1:0] major_code;
   wire [MIDDLE_BITS-1:0] middle_code;

   // assemble the word, msb on the top line
   assign sample_word = {sample_msb, sample_middle_bits, sample_lsb};

   // hold the word while powered down
   always @* begin
      if (power_down)
         next_word = latched_word;
      else
         next_word = sample_word;
   end

   // ************************************************************
   // input latch, rising edge only
   // ************************************************************

   // capture the full word; the pull-down is modelled by the testbench driving low
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         latched_word <= `DSD_WORD_RESET;
         low_power <= 1'b0;
      end else begin
         latched_word <= next_word;
         low_power <= power_down;
      end
   end

   assign major_code = latched_word[WORD_W-1:MAJOR_LSB];
   assign middle_code = latched_word[MAJOR_LSB-1:MIDDLE_LSB];
   // widen the middle group code to the decoder's five-bit index
   wire [4:0] major_idx;
   wire [4:0] middle_idx;
   assign major_idx = major_code;
   assign middle_idx = {1'b0, middle_code};
   assign major_therm = dsd_therm(major_idx);
   assign middle_therm = dsd_therm(middle_idx);

   // ************************************************************
   // steering registers, true and complement on one edge
   // ************************************************************

   // complements come from the same decode, so every pair flips together
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         major_sel <= {MAJOR_SEGS{1'b0}};
         major_sel_n <= {MAJOR_SEGS{1'b1}};
         middle_sel <= {MIDDLE_SEGS{1'b0}};
         middle_sel_n <= {MIDDLE_SEGS{1'b1}};
         low_sel <= {LOW_BITS{1'b0}};
         low_sel_n <= {LOW_BITS{1'b1}};
      end else begin
         major_sel <= major_therm[MAJOR_SEGS-1:0];
         major_sel_n <= ~major_therm[MAJOR_SEGS-1:0];
         middle_sel <= middle_therm[MIDDLE_SEGS-1:0];
         middle_sel_n <= ~middle_therm[MIDDLE_SEGS-1:0];
         low_sel <= latched_word[LOW_BITS-1:0];
         low_sel_n <= ~latched_word[LOW_BITS-1:0];
      end
   end

endmodule
`default_nettype wire

//--- design/dsd_defines.vh
// constants for the converter input latch and segment decoder
`ifndef DSD_DEFINES_VH
`define DSD_DEFINES_VH

// ************************************************************
// word layout
// ************************************************************
`define DSD_WORD_W 12
`define DSD_MAJOR_BITS 5
`define DSD_MIDDLE_BITS 4
`define DSD_LOW_BITS 3
`define DSD_MAJOR_SEGS 31
`define DSD_MIDDLE_SEGS 15
`define DSD_MAJOR_LSB 7
`define DSD_MIDDLE_LSB 3

// ************************************************************
// reset values and timing
// ************************************************************
`define DSD_WORD_RESET 12'h000
`define DSD_MAX_RATE_MSPS 125
`define DSD_REF_CLK_MHZ 100
`define DSD_PIPE_CYCLES 2

`endif

//--- verif/dsd_segment_decoder_asserts.sv
// port checks for the segment decoder
`timescale 1ns/100ps
`default_nettype none
module dsd_chk (
   input wire logic ref_clk, rst_n, sample_msb, sample_lsb, power_down, low_power,
   input wire logic [9:0] sample_middle_bits,
   input wire logic [11:0] latched_word,
   input wire logic [30:0] major_sel, major_sel_n,
   input wire logic [14:0] middle_sel, middle_sel_n,
   input wire logic [2:0] low_sel, low_sel_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_cap; !power_down |=> latched_word == $past({sample_msb, sample_middle_bits, sample_lsb}); endproperty
   a_cap: assert property (p_cap) else $error("capture");
   property p_hold; power_down |=> $stable(latched_word); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_lp; low_power == $past(power_down); endproperty
   a_lp: assert property (p_lp) else $error("low power");
   property p_pair; ~major_sel == major_sel_n && ~middle_sel == middle_sel_n && ~low_sel == low_sel_n; endproperty
   a_pair: assert property (p_pair) else $error("pair");
   property p_maj; major_sel == ~(31'h7fff_ffff << $past(latched_word[11:7])); endproperty
   a_maj: assert property (p_maj) else $error("major");
   property p_mid; middle_sel == ~(15'h7fff << $past(latched_word[6:3])); endproperty
   a_mid: assert property (p_mid) else $error("middle");
   property p_low; low_sel == $past(latched_word[2:0]); endproperty
   a_low: assert property (p_low) else $error("low");
   property p_ones; &latched_word |=> &{major_sel, middle_sel, low_sel}; endproperty
   a_ones: assert property (p_ones) else $error("ones");
endmodule
bind dsd_segment_decoder dsd_chk u_chk (.*);
`default_nettype wire

//--- verif/dsd_source_model.sv
// sample source that launches words just after each rising edge
`timescale 1ns/100ps
`default_nettype none
module dsd_source_model (
   input wire logic ref_clk, pd_req,
   input wire logic [11:0] word,
   output logic sample_msb = 0, sample_lsb = 0, power_down = 0,
   output logic [9:0] sample_middle_bits = 0
);
   // msb on the top line, lsb on line zero
   always @(posedge ref_clk) {sample_msb, sample_middle_bits, sample_lsb, power_down} <= {word, pd_req};
endmodule
`default_nettype wire

//--- verif/dsd_segment_decoder_tb.sv
// self-checking bench for the segment decoder
`timescale 1ns/100ps
`default_nettype none
module dsd_segment_decoder_tb;
   logic ref_clk = 0, rst_n = 0, pd_req = 0, p, done = 0;
   logic [48:0] x;
   logic [11:0] word = 0, held = 0, w, e, q[$];
   logic [31:0] rnd = 10393;
   int err_count = 0, total_checks = 0, cyc = 0;
   wire sample_msb, sample_lsb, power_down, low_power;
   wire [9:0] sample_middle_bits;
   wire [11:0] latched_word;
   wire [30:0] major_sel, major_sel_n;
   wire [14:0] middle_sel, middle_sel_n;
   wire [2:0] low_sel, low_sel_n;
   dsd_source_model src (.*);
   dsd_segment_decoder uut (.*);
   always #5 ref_clk = ~ref_clk; // 100 MHz
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task chk(input logic [48:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // back-to-back words, power-down keeps the held word
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1;
      for (int i = 0; i < 300; i++) begin
         @(posedge ref_clk);
         rnd = xs(rnd);
         w = i == 0 ? 12'hfff : i == 1 ? 12'h000 : rnd[11:0];
         p = i > 3 && rnd[14:12] == 0;
         word <= w;
         pd_req <= p; // low when idle
         if (!p) held = w;
         q.push_back(held);
      end
      done = 1;
      repeat (5) @(posedge ref_clk);
      tally_and_finish;
   end
   // steering shows three edges after a word is handed to the source
   always @(negedge ref_clk) if (q.size() == 4 || (done && q.size() > 0)) begin
      e = q.pop_front();
      x = {~(31'h7fff_ffff << e[11:7]), ~(15'h7fff << e[6:3]), e[2:0]};
      chk({major_sel, middle_sel, low_sel}, x);
      chk({major_sel_n, middle_sel_n, low_sel_n}, ~x);
   end
   always @(posedge ref_clk) if (++cyc > 1000) begin
      err_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
